// file: bench/ocr_ctrl_bank_test.sv
// Self-checking bench for the overcurrent and amplifier control bank
`timescale 1ns/1ps
module ocr_ctrl_bank_test
  import ocr_pkg::*;
;
  // Short retry counts keep the run brief
  localparam int LONG = 200;
  localparam int SHORT = 20;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  ocr_sense_type sense = '0;
  ocr_bus_req_type bus;
  logic [15:0] rd_data;
  logic [15:0] rd_na;
  ocr_ocp_cfg_type ocp_cfg;
  ocr_amp_cfg_type amp_cfg;
  ocr_amp_cfg_type amp_na;
  logic [6:0] dead;
  logic [11:0] filt;
  logic fault;
  logic prot;
  logic irq;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;

  initial forever #2 ref_clk_in = ~ref_clk_in;

  ocr_host_model host (.ref_clk_in(ref_clk_in), .bus_out(bus), .rd_data_in(rd_data));

  ocr_ctrl_bank #(.HAS_AMP(1), .RETRY_LONG_CYCLES(LONG), .RETRY_SHORT_CYCLES(SHORT)) DUT (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .bus_in(bus), .rd_data_out(rd_data),
    .sense_in(sense), .ocp_cfg_out(ocp_cfg), .amp_cfg_out(amp_cfg),
    .dead_time_cycles_out(dead), .filter_cycles_out(filt), .fault_out(fault),
    .protect_out(prot), .irq_out(irq));

  // Variant without amplifiers, sharing the same port traffic
  ocr_ctrl_bank #(.HAS_AMP(0), .RETRY_LONG_CYCLES(LONG), .RETRY_SHORT_CYCLES(SHORT)) DUT_NA (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .bus_in(bus), .rd_data_out(rd_na),
    .sense_in(sense), .ocp_cfg_out(), .amp_cfg_out(amp_na), .dead_time_cycles_out(),
    .filter_cycles_out(), .fault_out(), .protect_out(), .irq_out());

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    host.rd(a, q);
    chk(q, exp);
  endtask

  // Bounded wait for fault (sel 1) or protect (sel 0) to reach v
  task automatic wait_s(input logic sel, input logic v, input int lim, output int k);
    k = 0;
    while ((sel ? fault : prot) !== v && k < lim) begin
      @(posedge ref_clk_in);
      #1;
      k++;
    end
  endtask

  // Hold one comparator high until a fault shows or the wait runs out
  task automatic trip(input logic shunt, output int k);
    @(posedge ref_clk_in);
    if (shunt) sense.shunt_overcurrent <= 1'b1;
    else sense.drain_source_overcurrent <= 1'b1;
    wait_s(1'b1, 1'b1, 700, k);
    @(posedge ref_clk_in);
    sense <= '0;
    #1;
  endtask

  // Filter code 0 (500 cycles), dead code 01, trip level 1001
  task automatic set_ocp(input logic retry, input logic [1:0] mode);
    host.wr(8'h05, {5'h00, retry, 2'b01, mode, 2'b00, 4'h9});
  endtask

  task automatic t_reset();
    chk({5'h00, ocp_cfg}, 16'h0159);
    chk({5'h00, amp_cfg}, 16'h0283);
    chk({9'h000, dead}, 16'h0019);
    chk({4'h0, filt}, 16'h03e8);
    chkb(irq, 1'b0);
    rchk(8'h05, 16'h0159);
    rchk(8'h06, 16'h0283);
  endtask

  task automatic t_rw();
    logic [15:0] q;
    host.wr(8'h05, 16'hffff);
    rchk(8'h05, 16'h07ff);
    host.wr(8'h06, 16'h0400);
    rchk(8'h06, 16'h0500);
    host.wr(8'h06, 16'h02ff);
    rchk(8'h06, 16'h02ff);
    chk({5'h00, amp_cfg}, 16'h02ff);
    host.wr(8'h0f, 16'hffff);
    rchk(8'h0f, 16'h0000);
    rchk(8'h05, 16'h07ff);
    host.rd(8'h06, q);
    chk(rd_na, 16'h0000);
    chk({5'h00, amp_na}, 16'h0000);
    host.wr(8'h06, 16'h0283);
  endtask

  // Every dead-time and filter code, trip levels 0000, 0101, 1010 and 1111
  task automatic t_table();
    int dt[4] = '{13, 25, 50, 100};
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      host.wr(8'h05, {5'h00, 1'b0, c, 2'b01, c, c, c});
      @(posedge ref_clk_in);
      #1;
      chk({9'h000, dead}, 16'(dt[i]));
      chk({4'h0, filt}, 16'(500 * (i + 1)));
      rchk(8'h05, {5'h00, 1'b0, c, 2'b01, c, c, c});
    end
  endtask

  task automatic t_latch();
    host.wr(8'h09, 16'h0001);
    host.wr(8'h08, 16'h0003);
    set_ocp(1'b0, 2'b00);
    trip(1'b0, n);
    chkb(n >= 500 && n <= 510, 1'b1);
    chkb(prot, 1'b1);
    chkb(irq, 1'b1);
    repeat (50) @(posedge ref_clk_in);
    #1;
    chkb(prot, 1'b1);
    rchk(8'h0a, 16'h0003);
    host.wr(8'h07, 16'h0003);
    wait_s(1'b0, 1'b0, 4, n);
    chkb(prot, 1'b0);
    chkb(fault, 1'b0);
    chkb(irq, 1'b1);
    host.wr(8'h08, 16'h0001);
    chkb(irq, 1'b0);
  endtask

  // Masked event still sets status
  task automatic t_report();
    host.wr(8'h09, 16'h0000);
    host.wr(8'h08, 16'h0003);
    set_ocp(1'b0, 2'b10);
    trip(1'b0, n);
    chkb(fault, 1'b1);
    chkb(prot, 1'b0);
    chkb(irq, 1'b0);
    rchk(8'h08, 16'h0001);
    wait_s(1'b1, 1'b0, 10, n);
    chkb(fault, 1'b0);
  endtask

  task automatic t_ignore();
    host.wr(8'h08, 16'h0003);
    set_ocp(1'b0, 2'b11);
    trip(1'b0, n);
    chkb(fault, 1'b0);
    chkb(prot, 1'b0);
    rchk(8'h08, 16'h0000);
  endtask

  task automatic t_shunt();
    set_ocp(1'b0, 2'b10);
    host.wr(8'h06, 16'h02a3);
    trip(1'b1, n);
    chkb(fault, 1'b0);
    host.wr(8'h06, 16'h0283);
    host.wr(8'h08, 16'h0003);
    trip(1'b1, n);
    chkb(fault, 1'b1);
    rchk(8'h08, 16'h0002);
    wait_s(1'b1, 1'b0, 10, n);
    chkb(fault, 1'b0);
  endtask

  // Per-cycle clear off so only the retry count ends the fault
  task automatic t_retry();
    host.wr(8'h07, 16'h0000);
    set_ocp(1'b1, 2'b01);
    trip(1'b0, n);
    chkb(prot, 1'b1);
    wait_s(1'b0, 1'b0, 400, n);
    chkb(n >= SHORT - 3 && n <= SHORT + 3, 1'b1);
    set_ocp(1'b0, 2'b01);
    trip(1'b0, n);
    wait_s(1'b0, 1'b0, 400, n);
    chkb(n >= LONG - 3 && n <= LONG + 3, 1'b1);
  endtask

  task automatic t_cycle();
    host.wr(8'h07, 16'h0002);
    trip(1'b0, n);
    repeat (10) @(posedge ref_clk_in);
    #1;
    chkb(prot, 1'b1);
    @(posedge ref_clk_in);
    sense.pwm <= 1'b1;
    wait_s(1'b0, 1'b0, 12, n);
    chkb(n < 12, 1'b1);
    @(posedge ref_clk_in);
    sense.pwm <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    #1;
    t_reset();
    t_rw();
    t_table();
    t_latch();
    t_report();
    t_ignore();
    t_shunt();
    t_retry();
    t_cycle();
    end_of_test();
  end
endmodule

// file: bench/ocr_host_model.sv
// Host model speaking the plain register port of the control bank
`timescale 1ns/1ps
module ocr_host_model
  import ocr_pkg::*;
(
  // Clock
  input wire logic ref_clk_in,
  // Register port
  output ocr_bus_req_type bus_out,
  input wire logic [15:0] rd_data_in
);
  initial bus_out = '0;

  // One strobe cycle; return after the edge settles so callers see the effect
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    bus_out.wr <= 1'b0;
    #1;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge ref_clk_in);
    bus_out <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    bus_out.rd <= 1'b0;
    #1;
    q = rd_data_in;
  endtask
endmodule

// file: rtl/ocr_cfg.svh
// Offsets, field positions, reset values and timing of the control bank
`ifndef OCR_CFG_SVH
`define OCR_CFG_SVH

`define OCR_ADDR_OCP 8'h05
`define OCR_ADDR_AMP 8'h06
`define OCR_ADDR_CTRL 8'h07
`define OCR_ADDR_IRQ_STAT 8'h08
`define OCR_ADDR_IRQ_MASK 8'h09
`define OCR_ADDR_FLT 8'h0a

`define OCR_OCP_RESET 11'h159
`define OCR_AMP_RESET 11'h283
`define OCR_CTRL_RESET 2'h2
`define OCR_IRQ_MASK_RESET 2'h0

`define OCR_AMP_SRC_BIT 10
`define OCR_CTRL_CLEAR_BIT 0
`define OCR_CTRL_PCYC_BIT 1

`define OCR_CLK_MHZ 250
`define OCR_FILTER_STEP_NS 2000
`define OCR_DEAD_BASE_NS 50
`define OCR_RETRY_LONG_US 4000
`define OCR_RETRY_SHORT_NS 50000
`define OCR_RETRY_LONG_CYCLES (`OCR_RETRY_LONG_US * `OCR_CLK_MHZ)
`define OCR_RETRY_SHORT_CYCLES (`OCR_RETRY_SHORT_NS * `OCR_CLK_MHZ / 1000)

`endif

// file: rtl/ocr_ctrl_bank.sv
// Overcurrent protection and sense amplifier control registers
`timescale 1ns/1ps
`include "ocr_cfg.svh"
module ocr_ctrl_bank
  import ocr_pkg::*;
#(
  parameter int HAS_AMP = 1,
  parameter int RETRY_LONG_CYCLES = `OCR_RETRY_LONG_CYCLES,
  parameter int RETRY_SHORT_CYCLES = `OCR_RETRY_SHORT_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire ocr_bus_req_type bus_in,
  output logic [15:0] rd_data_out,
  // Comparator and PWM pins
  input wire ocr_sense_type sense_in,
  // Settings to the analog stage
  output ocr_ocp_cfg_type ocp_cfg_out,
  output ocr_amp_cfg_type amp_cfg_out,
  output logic [6:0] dead_time_cycles_out,
  output logic [11:0] filter_cycles_out,
  // Fault and interrupt
  output logic fault_out,
  output logic protect_out,
  output logic irq_out
);

  localparam logic AMP_LIVE = (HAS_AMP != 0);

  ocr_ocp_cfg_type ocp_cfg;
  ocr_amp_cfg_type amp_reg;
  logic per_cycle_fault_clear;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  ocr_sense_type sync1;
  ocr_sense_type sync2;
  logic pwm_d;
  logic pwm_edge;
  logic vds_trip;
  logic shunt_trip;
  logic vds_trip_d;
  logic shunt_trip_d;
  logic vds_evt;
  logic shunt_evt;
  logic shunt_live;
  logic fault_cond;
  logic clear_pulse;
  logic wr_ocp;
  logic wr_amp;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic [1:0] evt_set;
  logic [1:0] stat_clr;
  logic [11:0] filter_limit;
  logic [19:0] retry_limit;
  logic [19:0] retry_cnt;
  logic retry_done;
  logic [15:0] next_rd_data;
  ocr_response_type resp;
  ocr_fault_state_type state;
  ocr_fault_state_type next_state;

  function automatic logic [11:0] filter_cycles(input logic [1:0] sel);
    filter_cycles = 12'((32'(sel) + 1) * `OCR_FILTER_STEP_NS * `OCR_CLK_MHZ / 1000);
  endfunction

  // Least time, so round up to whole cycles
  function automatic logic [6:0] dead_cycles(input logic [1:0] sel);
    dead_cycles = 7'(((`OCR_DEAD_BASE_NS << sel) * `OCR_CLK_MHZ + 999) / 1000);
  endfunction

  // Write decode
  assign wr_ocp = bus_in.wr && (bus_in.addr == `OCR_ADDR_OCP);
  assign wr_amp = bus_in.wr && (bus_in.addr == `OCR_ADDR_AMP) && AMP_LIVE;
  assign wr_ctrl = bus_in.wr && (bus_in.addr == `OCR_ADDR_CTRL);
  assign wr_stat = bus_in.wr && (bus_in.addr == `OCR_ADDR_IRQ_STAT);
  assign wr_mask = bus_in.wr && (bus_in.addr == `OCR_ADDR_IRQ_MASK);
  assign clear_pulse = wr_ctrl && bus_in.wdata[`OCR_CTRL_CLEAR_BIT];

  // protection settings, reset 1001 trip level
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ocp_cfg <= ocr_ocp_cfg_type'(`OCR_OCP_RESET);
    end else if (wr_ocp) begin
      ocp_cfg <= ocr_ocp_cfg_type'(bus_in.wdata[10:0]);
    end
  end

  // amplifier settings with their reset codes
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      amp_reg <= ocr_amp_cfg_type'(`OCR_AMP_RESET);
    end else if (wr_amp) begin
      amp_reg <= ocr_amp_cfg_type'(bus_in.wdata[10:0]);
      if (bus_in.wdata[`OCR_AMP_SRC_BIT]) begin
        amp_reg.low_side_measure_ref <= 1'b1;
      end
    end
  end

  // Per-cycle clear enable, on by default
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      per_cycle_fault_clear <= 1'(`OCR_CTRL_RESET >> `OCR_CTRL_PCYC_BIT);
    end else if (wr_ctrl) begin
      per_cycle_fault_clear <= bus_in.wdata[`OCR_CTRL_PCYC_BIT];
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_mask <= `OCR_IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask <= bus_in.wdata[1:0];
    end
  end

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
      pwm_d <= 1'b0;
    end else begin
      sync1 <= sense_in;
      sync2 <= sync1;
      pwm_d <= sync2.pwm;
    end
  end

  assign pwm_edge = sync2.pwm && !pwm_d;
  assign resp = ocp_cfg.overcurrent_response_sel;

  // filter length from the selected code
  assign filter_limit = filter_cycles(ocp_cfg.overcurrent_filter_sel);

  ocr_deglitch #(
    .CNT_W(12)
  ) u_vds_filter (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .level_in(sync2.drain_source_overcurrent),
    .limit_in(filter_limit),
    .trip_out(vds_trip)
  );

  ocr_deglitch #(
    .CNT_W(12)
  ) u_shunt_filter (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .level_in(sync2.shunt_overcurrent),
    .limit_in(filter_limit),
    .trip_out(shunt_trip)
  );

  // shunt fault only with amplifiers and not disabled
  assign shunt_live = AMP_LIVE && !amp_reg.shunt_fault_disable;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vds_trip_d <= 1'b0;
      shunt_trip_d <= 1'b0;
    end else begin
      vds_trip_d <= vds_trip;
      shunt_trip_d <= shunt_trip && shunt_live;
    end
  end

  assign vds_evt = vds_trip && !vds_trip_d;
  assign shunt_evt = shunt_trip && shunt_live && !shunt_trip_d;
  assign fault_cond = vds_trip || (shunt_trip && shunt_live);

  // nothing is recorded in ignore mode
  assign evt_set = (resp == RSP_IGNORE) ? 2'h0 : {shunt_evt, vds_evt};
  assign stat_clr = wr_stat ? bus_in.wdata[1:0] : 2'h0;

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (irq_status & ~stat_clr) | evt_set;
    end
  end

  assign irq_out = |(irq_status & irq_mask);

  assign retry_limit = ocp_cfg.fault_retry_interval_sel ? 20'(RETRY_SHORT_CYCLES)
                                                        : 20'(RETRY_LONG_CYCLES);
  assign retry_done = (retry_cnt >= retry_limit - 20'h0_0001);

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      retry_cnt <= 20'h0_0000;
    end else if (state != FLT_RETRY) begin
      retry_cnt <= 20'h0_0000;
    end else begin
      retry_cnt <= retry_cnt + 20'h0_0001;
    end
  end

  // Fault response sequencing
  always_comb begin
    next_state = state;
    case (state)
      FLT_IDLE: begin
        if (fault_cond && resp == RSP_LATCH) begin
          next_state = FLT_LATCHED;
        end else if (fault_cond && resp == RSP_RETRY) begin
          next_state = FLT_RETRY;
        end
      end
      FLT_LATCHED: begin
        if (clear_pulse) begin
          next_state = FLT_IDLE;
        end
      end
      FLT_RETRY: begin
        // early clear at the next PWM edge
        if (per_cycle_fault_clear && pwm_edge) begin
          next_state = FLT_IDLE;
        end else if (retry_done || clear_pulse) begin
          next_state = FLT_IDLE;
        end
      end
      default: begin
        next_state = FLT_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= FLT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // report mode flags the fault but never protects
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      protect_out <= 1'b0;
      fault_out <= 1'b0;
    end else begin
      protect_out <= (next_state != FLT_IDLE);
      fault_out <= (next_state != FLT_IDLE) || (resp == RSP_REPORT && fault_cond);
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dead_time_cycles_out <= dead_cycles(2'h1);
      filter_cycles_out <= filter_cycles(2'h1);
    end else begin
      dead_time_cycles_out <= dead_cycles(ocp_cfg.dead_time_sel);
      filter_cycles_out <= filter_limit;
    end
  end

  // settings drive the analog stage straight from flops
  assign ocp_cfg_out = ocp_cfg;
  assign amp_cfg_out = AMP_LIVE ? amp_reg : '0;

  // readback; missing amplifier register reads zero
  always_comb begin
    case (bus_in.addr)
      `OCR_ADDR_OCP: next_rd_data = {5'h00, ocp_cfg};
      `OCR_ADDR_AMP: next_rd_data = AMP_LIVE ? {5'h00, amp_reg} : 16'h0000;
      `OCR_ADDR_CTRL: next_rd_data = {14'h0000, per_cycle_fault_clear, 1'b0};
      `OCR_ADDR_IRQ_STAT: next_rd_data = {14'h0000, irq_status};
      `OCR_ADDR_IRQ_MASK: next_rd_data = {14'h0000, irq_mask};
      `OCR_ADDR_FLT: next_rd_data = {13'h0000, state == FLT_RETRY, fault_out, protect_out};
      default: next_rd_data = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= 16'h0000;
    end else if (bus_in.rd) begin
      rd_data_out <= next_rd_data;
    end else begin
      rd_data_out <= 16'h0000;
    end
  end

  default clocking ast_clk @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  AST_RETRY_BOUND: assert property (state == FLT_RETRY |-> retry_cnt < retry_limit)
    else $error("retry wait ran past the selected interval");

  AST_DEAD_TIME: assert property (
    dead_time_cycles_out == dead_cycles($past(ocp_cfg.dead_time_sel)))
    else $error("dead time count does not follow its code");

  AST_LATCH_HOLD: assert property (state == FLT_LATCHED && !clear_pulse
    |=> state == FLT_LATCHED && protect_out)
    else $error("latched fault left without a clear");

  AST_RETRY_EXIT: assert property (state == FLT_RETRY && retry_done
    |=> state == FLT_IDLE && !protect_out)
    else $error("retrying fault did not clear after its interval");

  AST_REPORT_ONLY: assert property (resp == RSP_REPORT && state == FLT_IDLE && !wr_ocp
    |=> state == FLT_IDLE)
    else $error("report-only mode took protective action");

  AST_IGNORE_SILENT: assert property (resp == RSP_IGNORE && !wr_ocp
    |=> (irq_status & ~$past(irq_status)) == 2'h0)
    else $error("ignore mode recorded an overcurrent");

  AST_FORCE_REF: assert property (wr_amp && bus_in.wdata[`OCR_AMP_SRC_BIT]
    |=> amp_reg.low_side_measure_ref)
    else $error("switch-node input did not force the low-side reference");

  AST_SHUNT_OFF: assert property (amp_reg.shunt_fault_disable
    |=> !(irq_status[1] && !$past(irq_status[1])))
    else $error("disabled shunt fault still raised an event");

  AST_READ_BACK: assert property (bus_in.rd && bus_in.addr == `OCR_ADDR_OCP && !wr_ocp
    |=> rd_data_out == {5'h00, $past(ocp_cfg)})
    else $error("protection register readback mismatch");

  AST_NO_AMP: assert property (!AMP_LIVE && bus_in.rd && bus_in.addr == `OCR_ADDR_AMP
    |=> rd_data_out == 16'h0000)
    else $error("absent amplifier register answered");

  AST_PER_CYCLE: assert property (state == FLT_RETRY && per_cycle_fault_clear && pwm_edge
    |=> state == FLT_IDLE)
    else $error("PWM edge did not clear the retrying fault");

endmodule

// file: rtl/ocr_deglitch.sv
// Persistence filter for one overcurrent comparator level
`timescale 1ns/1ps
module ocr_deglitch #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Comparator level and hold time in cycles
  input wire logic level_in,
  input wire logic [CNT_W-1:0] limit_in,
  // Filtered level
  output logic trip_out
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (!level_in) begin
      next_count = '0;
    end else if (count < limit_in) begin
      next_count = count + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= '0;
      trip_out <= 1'b0;
    end else begin
      count <= next_count;
      trip_out <= level_in && (next_count >= limit_in);
    end
  end

  default clocking ast_clk @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  AST_FILTER_DROP: assert property (!level_in |=> !trip_out)
    else $error("filtered trip outlived its comparator level");
  AST_FILTER_HOLD: assert property ($rose(trip_out)
    |-> $past(level_in, 1) && $past(level_in, 2))
    else $error("filtered trip rose without a persisting level");

endmodule

// file: rtl/ocr_pkg.sv
// Types shared by the overcurrent and amplifier control bank
package ocr_pkg;

  typedef enum logic [1:0] {
    RSP_LATCH = 2'h0,
    RSP_RETRY = 2'h1,
    RSP_REPORT = 2'h2,
    RSP_IGNORE = 2'h3
  } ocr_response_type;

  typedef enum logic [1:0] {
    FLT_IDLE,
    FLT_LATCHED,
    FLT_RETRY
  } ocr_fault_state_type;

  typedef struct packed {
    logic fault_retry_interval_sel;
    logic [1:0] dead_time_sel;
    ocr_response_type overcurrent_response_sel;
    logic [1:0] overcurrent_filter_sel;
    logic [3:0] drain_source_trip_level;
  } ocr_ocp_cfg_type;

  typedef struct packed {
    logic amp_input_source_sel;
    logic ref_half_sel;
    logic low_side_measure_ref;
    logic [1:0] amp_gain_sel;
    logic shunt_fault_disable;
    logic amp_a_offset_cal;
    logic amp_b_offset_cal;
    logic amp_c_offset_cal;
    logic [1:0] shunt_trip_level;
  } ocr_amp_cfg_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ocr_bus_req_type;

  typedef struct packed {
    logic drain_source_overcurrent;
    logic shunt_overcurrent;
    logic pwm;
  } ocr_sense_type;

endpackage
